/* File: inc/bdws_pkg.sv */
// Overview of operation
// R01: Four-beat sequential page-mode write burst supported
// R02: First column strobe latches address and data
// R03: Lane strobes follow current beat byte enables
// R04: Processor byte enables timed like address
// R05: Abort internal burst after first beat
// R06: Two stall cycles before later beats
// R07: Second strobe writes second beat, lane-selected
// R08: Beat countdown ignored during write bursts
// R09: Third strobe carries fresh column address
// R10: Fourth strobe carries final beat, own address
// R11: Whole burst takes 281.25 ns; the sequencer here takes 15 cycles of 40 ns, 600 ns
// R12: Row strobe negates, precharge starts
// R13: Toggle write-enable to terminate burst
// R14: Return idle, accept next request
package bdws_pkg;
    localparam int          BDWS_DATA_W      = 32;
    localparam int          BDWS_ADDR_W      = 10;
    localparam int          BDWS_LANES       = 4;
    localparam int          BDWS_BEATS       = 4;
    localparam int          BDWS_FIFO_DEPTH  = 32;
    localparam int          BDWS_STALLS      = 2;
    localparam int          BDWS_CLK_PS      = 40000;
    localparam int          BDWS_BURST_PS    = 281250;
    // Burst budget in whole cycles, rounded down as a longest time
    localparam int          BDWS_BURST_CYC   = BDWS_BURST_PS / BDWS_CLK_PS;
    localparam int          BDWS_PRECHG_CYC  = 1;
    localparam logic [1:0]  BDWS_BCNT_RST    = 2'h3;
    localparam logic [31:0] BDWS_EXAMPLE_ADR = 32'h00000008;

    typedef enum logic [2:0] {
        BDWS_IDLE,
        BDWS_ROW,
        BDWS_CAS,
        BDWS_CAS_OFF,
        BDWS_STALL,
        BDWS_PRECHG
    } bdws_state_e;
endpackage

/* File: rtl/bdws_fifo.sv */
`timescale 1ns/1ps
module bdws_fifo #(
    parameter int W     = 36,
    parameter int DEPTH = 32
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
        logic          ov;
        logic [W-1:0]  od;
    } bdws_fifo_s;

    bdws_fifo_s   st_q;
    bdws_fifo_s   st_d;
    logic [W-1:0] mem [DEPTH];
    logic         push;
    logic         pop;
    logic         load;

    assign in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
    assign out_valid = st_q.ov;
    assign out_data  = st_q.od;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    // Output register refills whenever it is empty or being drained and the array holds an entry
    assign load      = (st_q.cnt != '0) && (!st_q.ov || pop);

    // Storage array carries no reset, keeps it in plain memory
    always_ff @(posedge clk)
    begin
        if (push)
            mem[st_q.wp] <= in_data;
    end

    // Pointer, fill count and output register update
    always_comb
    begin
        st_d = st_q;
        if (push)
            st_d.wp = st_q.wp + 1'b1;
        if (load)
        begin
            st_d.rp = st_q.rp + 1'b1;
            st_d.od = mem[st_q.rp];
            st_d.ov = 1'b1;
        end
        else if (pop)
            st_d.ov = 1'b0;
        st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(load);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            st_q <= '0;
        else
            st_q <= st_d;
    end
endmodule

/* File: rtl/bdws_seq.sv */
`timescale 1ns/1ps
module bdws_seq #(
    parameter int DATA_W = bdws_pkg::BDWS_DATA_W,
    parameter int ADDR_W = bdws_pkg::BDWS_ADDR_W,
    parameter int DEPTH  = bdws_pkg::BDWS_FIFO_DEPTH
) (
    input  wire logic                            clk,
    input  wire logic                            rstn,
    // Processor side: one beat per handshake, burst opened by the first queued wr_valid beat
    input  wire logic                            wr_valid,
    output logic                                 wr_ready,
    input  wire logic [ADDR_W-1:0]               wr_row,
    input  wire logic [ADDR_W-1:0]               wr_col,
    input  wire logic [bdws_pkg::BDWS_LANES-1:0] wr_be,
    input  wire logic [DATA_W-1:0]               wr_data,
    input  wire logic                            wr_last,
    output logic                                 busy,
    output logic                                 burst_done,
    // Memory side
    output logic                                 ras_n,
    output logic [bdws_pkg::BDWS_LANES-1:0]      cas_n,
    output logic                                 dram_we_n,
    output logic [ADDR_W-1:0]                    dram_addr,
    output logic [DATA_W-1:0]                    dram_dq,
    output logic                                 dram_dq_oe,
    output logic [7:0]                           memory_sequencer_state,
    output logic [8:0]                           burst_cycles
);
    import bdws_pkg::*;

    localparam int FW = 2*ADDR_W + BDWS_LANES + DATA_W + 1;

    typedef struct packed {
        bdws_state_e             st;
        logic [1:0]              beat;
        logic [1:0]              stall;
        logic [1:0]              bcnt;
        logic                    ras_n;
        logic [BDWS_LANES-1:0]   cas_n;
        logic                    we_n;
        logic [ADDR_W-1:0]       addr;
        logic [DATA_W-1:0]       dq;
        logic                    oe;
        logic                    done;
        logic [8:0]              cyc;
        logic [8:0]              cyc_run;
    } bdws_seq_s;

    bdws_seq_s         st_q;
    bdws_seq_s         st_d;
    logic              f_valid;
    logic              f_ready;
    logic [FW-1:0]     f_data;
    logic [ADDR_W-1:0] f_row;
    logic [ADDR_W-1:0] f_col;
    logic [BDWS_LANES-1:0] f_be;
    logic [DATA_W-1:0] f_dq;
    logic              f_last;

    // Beats queue here so the processor can run ahead of the stalls
    bdws_fifo #(
        .W     (FW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   ({wr_row, wr_col, wr_be, wr_data, wr_last}),
        .out_valid (f_valid),
        .out_ready (f_ready),
        .out_data  (f_data)
    );

    assign {f_row, f_col, f_be, f_dq, f_last} = f_data;

    // Lane strobes active low; an empty enable set still takes its beat slot but strobes no lane
    function automatic logic [BDWS_LANES-1:0] lane_cas(input logic [BDWS_LANES-1:0] be);
        lane_cas = ~be; // R03
    endfunction

    // A beat is consumed on each column strobe
    assign f_ready = (st_q.st == BDWS_CAS) && f_valid;

    // Burst state walk: row open, strobe, abort, stalls, strobe, precharge
    always_comb
    begin
        st_d      = st_q;
        st_d.done = 1'b0;
        st_d.cyc_run = (st_q.st == BDWS_IDLE) ? 9'h000 : st_q.cyc_run + 9'h001;
        case (st_q.st)
            BDWS_IDLE:
            begin
                st_d.ras_n = 1'b1;
                st_d.cas_n = '1;
                st_d.we_n  = 1'b1;
                st_d.oe    = 1'b0;
                st_d.beat  = 2'h0;
                st_d.bcnt  = BDWS_BCNT_RST;
                if (f_valid)
                begin
                    st_d.st    = BDWS_ROW; // R01
                    st_d.addr  = f_row;
                    st_d.ras_n = 1'b0;
                end
            end
            BDWS_ROW:
            begin
                st_d.st   = BDWS_CAS;
                st_d.addr = f_col;
                st_d.dq   = f_dq;
                st_d.oe   = 1'b1;
                st_d.we_n = 1'b0;
            end
            BDWS_CAS:
            begin
                // Address and data both latched on this strobe edge
                st_d.cas_n = lane_cas(f_be); // R02 R07 R09 R10
                st_d.bcnt  = st_q.bcnt - 2'h1; // R08
                st_d.st    = BDWS_CAS_OFF;
            end
            BDWS_CAS_OFF:
            begin
                st_d.cas_n = '1;
                st_d.beat  = st_q.beat + 2'h1;
                // Abort after every beat: skipped lanes would desync the counter,
                // and each later beat needs its own fresh address latch
                st_d.we_n  = 1'b1; // R05 R13
                if (st_q.beat == 2'(BDWS_BEATS-1))
                begin
                    st_d.st    = BDWS_PRECHG;
                    st_d.ras_n = 1'b1; // R12
                    st_d.we_n  = 1'b1; // R13
                    st_d.oe    = 1'b0;
                end
                else
                begin
                    st_d.st    = BDWS_STALL; // R06
                    st_d.stall = 2'h0;
                end
            end
            BDWS_STALL:
            begin
                st_d.stall = st_q.stall + 2'h1;
                if (st_q.stall == 2'(BDWS_STALLS-1) && f_valid)
                begin
                    // Fresh column address every later beat
                    st_d.st   = BDWS_CAS; // R06 R09
                    st_d.addr = f_col;
                    st_d.dq   = f_dq;
                    st_d.we_n = 1'b0;
                end
                else if (st_q.stall == 2'(BDWS_STALLS-1))
                    st_d.stall = st_q.stall;
            end
            BDWS_PRECHG:
            begin
                st_d.st   = BDWS_IDLE; // R14
                st_d.done = 1'b1;
                st_d.cyc  = st_q.cyc_run; // R11
            end
            default:
                st_d.st = BDWS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q       <= '0;
            st_q.st    <= BDWS_IDLE;
            st_q.ras_n <= 1'b1;
            st_q.cas_n <= '1;
            st_q.we_n  <= 1'b1;
            st_q.bcnt  <= BDWS_BCNT_RST;
        end
        else
            st_q <= st_d;
    end

    assign ras_n                  = st_q.ras_n;
    assign cas_n                  = st_q.cas_n;
    assign dram_we_n              = st_q.we_n;
    assign dram_addr              = st_q.addr;
    assign dram_dq                = st_q.dq;
    assign dram_dq_oe             = st_q.oe;
    assign busy                   = (st_q.st != BDWS_IDLE);
    assign burst_done             = st_q.done;
    assign memory_sequencer_state = {5'h00, st_q.st};
    assign burst_cycles           = st_q.cyc;
endmodule

/* File: tb/bdws_seq_asserts.sv */
`timescale 1ns/1ps
module bdws_seq_asserts (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       busy,
    input wire logic       burst_done,
    input wire logic       ras_n,
    input wire logic [3:0] cas_n,
    input wire logic       dram_we_n,
    input wire logic       dram_dq_oe
);
    logic [2:0] n_cas_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Strobes of the open row; cleared while the row is closed
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn || ras_n)
            n_cas_q <= 3'h0;
        else if (cas_n != 4'hf)
            n_cas_q <= n_cas_q + 3'h1;
    end
    sequence s_strobe;
        cas_n != 4'hf;
    endsequence
    // Stall gap that lets the next byte enables settle
    sequence s_gap;
        (cas_n == 4'hf) [*3];
    endsequence
    a_cas_in_row: assert property (s_strobe |-> !ras_n && dram_dq_oe && !dram_we_n)
        else $error("strobe outside an open write row");
    a_stall_gap: assert property (s_strobe |=> s_gap)
        else $error("column strobes closer than two stalls");
    a_abort_after: assert property (s_strobe |=> dram_we_n)
        else $error("write enable not raised after a beat");
    a_four_strobes: assert property ($rose(ras_n) |-> n_cas_q == 3'h4)
        else $error("burst closed without four strobes");
    a_row_held: assert property ($fell(ras_n) |-> (!ras_n && busy) [*8])
        else $error("row closed early");
    a_precharge_off: assert property ($rose(ras_n) |-> !dram_dq_oe && cas_n == 4'hf)
        else $error("bus still driven at precharge");
    a_done_after: assert property ($rose(ras_n) |-> ##[1:3] burst_done)
        else $error("no completion after precharge");
    a_done_pulse: assert property (burst_done |=> !burst_done)
        else $error("completion longer than one cycle");
endmodule
bind bdws_seq bdws_seq_asserts bdws_seq_asserts_i (.clk(clk), .rstn(rstn), .busy(busy),
    .burst_done(burst_done), .ras_n(ras_n), .cas_n(cas_n), .dram_we_n(dram_we_n),
    .dram_dq_oe(dram_dq_oe));

/* File: tb/bdws_dram.sv */
`timescale 1ns/1ps
module bdws_dram (
    input wire logic        clk,
    input wire logic        ras_n,
    input wire logic [3:0]  cas_n,
    input wire logic        dram_we_n,
    input wire logic [9:0]  dram_addr,
    input wire logic [31:0] dram_dq
);
    logic [31:0] mem [1024];
    initial
    begin
        for (int k = 0; k < 1024; k++)
            mem[k] = 32'h0;
    end
    // Each lane latches column and data only on its own strobe;
    // a strobe with write enable high would be a read, so it stores nothing
    always @(posedge clk)
    begin
        for (int k = 0; k < 4; k++)
            if (!ras_n && !cas_n[k] && !dram_we_n)
                mem[dram_addr][8*k+:8] <= dram_dq[8*k+:8];
    end
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        wr_valid = 1'b0;
    logic        wr_last = 1'b0;
    logic [9:0]  wr_row = 10'h000;
    logic [9:0]  wr_col = 10'h000;
    logic [3:0]  wr_be = 4'hf;
    logic [31:0] wr_data = 32'h0;
    logic        wr_ready, busy, burst_done, ras_n, dram_we_n, dram_dq_oe;
    logic [3:0]  cas_n;
    logic [9:0]  dram_addr;
    logic [31:0] dram_dq;
    logic [8:0]  burst_cycles;
    logic [7:0]  seq_state;
    // Row cycle, strobe and release per beat, stalls between beats
    localparam int EXP_CYC = 1 + 2 * bdws_pkg::BDWS_BEATS
                             + bdws_pkg::BDWS_STALLS * (bdws_pkg::BDWS_BEATS - 1);
    logic [31:0] sh [1024];
    int          n_errors = 0;
    int          checks = 0;
    int          n_full = 0;
    int          n_done = 0;
    int          exp_done = 0;
    // 25 MHz clock; completions counted as they come
    always #20 clk = ~clk;
    always @(posedge clk) if (burst_done === 1'b1) n_done++;
    bdws_seq bdws_seq_i (.clk(clk), .rstn(rstn), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_row(wr_row), .wr_col(wr_col), .wr_be(wr_be), .wr_data(wr_data),
        .wr_last(wr_last), .busy(busy), .burst_done(burst_done), .ras_n(ras_n),
        .cas_n(cas_n), .dram_we_n(dram_we_n), .dram_addr(dram_addr), .dram_dq(dram_dq),
        .dram_dq_oe(dram_dq_oe), .memory_sequencer_state(seq_state),
        .burst_cycles(burst_cycles));
    bdws_dram bdws_dram_i (.clk(clk), .ras_n(ras_n), .cas_n(cas_n), .dram_we_n(dram_we_n),
        .dram_addr(dram_addr), .dram_dq(dram_dq));
    task check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Holds the beat until an edge sees ready high; a full queue is noted
    task push(input logic [9:0] c, input logic [3:0] b, input logic [31:0] d);
        int i;
        logic r;
        wr_valid <= 1'b1;
        wr_row <= {2'h0, c[9:2]};
        wr_col <= c;
        wr_be <= b;
        wr_data <= d;
        for (i = 0; i < 500; i++)
        begin
            @(negedge clk) r = wr_ready;
            if (r !== 1'b1) n_full++;
            @(posedge clk);
            if (r === 1'b1) break;
        end
        if (i == 500) begin n_errors++; end_sim(); end
        for (i = 0; i < 4; i++) if (b[i]) sh[c][8*i+:8] = d[8*i+:8];
    endtask
    task burst(input logic [9:0] c, input logic [15:0] bes, input logic [31:0] d);
        exp_done++;
        for (int j = 0; j < 4; j++)
        begin
            wr_last <= (j == 3);
            push(c + 10'(j), bes[4*j+:4], d + 32'h11111111 * j);
        end
    endtask
    // Drain, then judge completions and memory contents
    task settle(input int lo, input int hi);
        int i, q;
        q = 0;
        wr_valid <= 1'b0;
        for (i = 0; i < 4000 && q < 4; i++)
        begin
            @(posedge clk);
            q = busy === 1'b0 ? q + 1 : 0;
        end
        if (q < 4)
        begin
            n_errors++;
            end_sim();
        end
        check(32'(n_done), 32'(exp_done));
        check(32'(seq_state), 32'(bdws_pkg::BDWS_IDLE));
        check(32'(burst_cycles), 32'(EXP_CYC));
        for (i = lo; i <= hi; i++) check(bdws_dram_i.mem[i], sh[i]);
    endtask
    task s_example;
        burst(10'h002, 16'hffff, 32'h8899aabb);
        settle(2, 5);
    endtask
    task s_merge;
        burst(10'h002, 16'h9681, 32'h01020304);
        settle(0, 7);
    endtask
    task s_fill;
        for (int k = 0; k < 12; k++) burst(10'(16 + 4 * k), 16'hf3c5, 32'(k));
        settle(16, 63);
        check(32'(n_full != 0), 32'h1);
    endtask
    initial
    begin
        for (int k = 0; k < 1024; k++) sh[k] = 32'h0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        s_example();
        s_merge();
        s_fill();
        end_sim();
    end
endmodule
